/* rtl/serial_io_params.svh */
// constants of the serial i/o block: offsets, fields, reset values
`ifndef SERIAL_IO_PARAMS_SVH
`define SERIAL_IO_PARAMS_SVH
// ==========================================================
// register indices, byte address = 4 * index
`define IDX_CTRL_ONE 10'h019
`define IDX_CTRL_TWO 10'h01a
`define IDX_STATUS 10'h01b
`define IDX_DATA 10'h01c
`define IDX_IRQ_STAT 10'h01d
`define IDX_IRQ_MASK 10'h01e
// ==========================================================
// fields
`define CTRL_RUN_BIT 7
`define CTRL_ABORT_BIT 6
`define CTRL_MODE_LSB 4
`define CTRL_DIR_BIT 3
`define COUNT_W 5
`define BUF_DEPTH 32
`define STATUS_RESET 8'h20
`define SCK_EXTERNAL 3'h7
`define IRQ_DONE_BIT 0
`define IRQ_ERR_BIT 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// ==========================================================
// internal clock: bit period 2^exp cycles of aclk
`define EXP_SCK0 4'hd
`define EXP_SCK1 4'h8
`define EXP_SCK2 4'h6
`define EXP_SCK3 4'h5
`define EXP_SCK4 4'h4
`define EXP_SCK5 4'h3
`define EXP_SCK6 4'h2
`endif

/* rtl/serial_io_pkg.sv */
// types shared by the serial i/o block
`default_nettype none
`include "serial_io_params.svh"
package serial_io_pkg;
  typedef enum logic [1:0] {MODE_TX, MODE_RX, MODE_BOTH, MODE_RESERVED} mode_type;

  typedef struct packed {
    logic sck_in;
    logic si_in;
  } pins_in_type;

  typedef struct packed {
    logic sck_out;
    logic sck_oe;
    logic so_out;
  } pins_out_type;

  typedef struct packed {
    logic run;
    logic abort;
    mode_type mode;
    logic dir;
    logic [2:0] sck_sel;
    logic [`COUNT_W-1:0] count_field;
    logic xfer_active;
    logic shift_active;
    logic tx_flag;
    logic rx_flag;
    logic tx_err;
    logic rx_err;
    logic [`BUF_DEPTH-1:0][7:0] mem;
    logic [4:0] wptr;
    logic [4:0] rptr;
    logic [4:0] sptr;
    logic [5:0] bytes_done;
    logic [5:0] rd_count;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic sck_level;
    logic ext_prev;
    logic so;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic aw_got;
    logic [9:0] aw_idx;
    logic w_got;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_type;
endpackage
`default_nettype wire

/* rtl/sync_two_stage.sv */
// two flip-flop synchroniser for pin inputs
`default_nettype none
module sync_two_stage #(
  parameter int W = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_type;

  sync_state_type r;
  sync_state_type n;

  always_comb begin
    n.meta = d;
    n.stable = r.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.stable;
endmodule
`default_nettype wire

/* rtl/half_bit_divider.sv */
// divider giving one-cycle ticks at half the serial bit period
`default_nettype none
module half_bit_divider (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic [3:0] exponent,
  output logic tick
);
  logic [12:0] cnt_reg;
  logic [12:0] cnt_next;
  logic [12:0] limit;

  // half period is 2^(exponent-1) cycles
  assign limit = (13'h0001 << (exponent - 4'h1)) - 13'h0001;
  assign tick = enable && (cnt_reg == limit);

  always_comb begin
    if (!enable || tick) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + 13'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

/* rtl/serial_io.sv */
// serial i/o unit: status flags, shared data buffer, shifter, axi4-lite slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`default_nettype none
`include "serial_io_params.svh"
module serial_io
  import serial_io_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire pins_in_type pins_in,
  output pins_out_type pins_out,
  output logic irq
);
  state_type r;
  state_type n;

  logic [1:0] pin_sync;
  logic sck_sync;
  logic si_sync;
  logic internal;
  logic tick;
  logic [3:0] exponent;
  logic [5:0] nbytes;
  logic [7:0] rx_byte;
  logic fall;
  logic rise;
  logic ev_done;
  logic rx_set;
  logic tx_err_set;
  logic rx_err_set;
  logic wr_fire;
  logic [7:0] status_byte;

  // ==========================================================
  // pin synchronisers and bit clock

  sync_two_stage #(
    .W(2)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({pins_in.sck_in, pins_in.si_in}),
    .q(pin_sync)
  );

  assign sck_sync = pin_sync[1];
  assign si_sync = pin_sync[0];
  assign internal = (r.sck_sel != `SCK_EXTERNAL);

  always_comb begin
    unique case (r.sck_sel)
      3'h0: exponent = `EXP_SCK0;
      3'h1: exponent = `EXP_SCK1;
      3'h2: exponent = `EXP_SCK2;
      3'h3: exponent = `EXP_SCK3;
      3'h4: exponent = `EXP_SCK4;
      3'h5: exponent = `EXP_SCK5;
      3'h6: exponent = `EXP_SCK6;
      3'h7: exponent = `EXP_SCK6;
    endcase
  end

  half_bit_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(r.shift_active && internal),
    .exponent(exponent),
    .tick(tick)
  );

  // ==========================================================
  // status layout
  // six flags, low bits read zero
  assign status_byte = {r.xfer_active, r.shift_active, r.tx_flag,
                        r.rx_flag, r.tx_err, r.rx_err, 2'b00};

  // ==========================================================
  // next state
  always_comb begin
    n = r;
    wr_fire = 1'b0;
    ev_done = 1'b0;
    rx_set = 1'b0;
    tx_err_set = 1'b0;
    rx_err_set = 1'b0;
    fall = 1'b0;
    rise = 1'b0;
    rx_byte = '0;
    nbytes = {1'b0, r.count_field} + 6'h01;
    n.ext_prev = sck_sync;

    if (r.run && !r.xfer_active && !r.abort) begin
      n.xfer_active = 1'b1;
      n.shift_active = 1'b1;
      n.sptr = '0;
      n.rptr = '0;
      n.rd_count = '0;
      n.bytes_done = '0;
      n.bitcnt = '0;
      n.shreg = r.mem[0];
      n.sck_level = 1'b1;
    end else if (r.shift_active) begin
      fall = internal ? (tick && r.sck_level) : (r.ext_prev && !sck_sync);
      rise = internal ? (tick && !r.sck_level) : (!r.ext_prev && sck_sync);
      // leading edge drives, trailing edge samples
      if (fall) begin
        n.sck_level = 1'b0;
        n.so = r.dir ? r.shreg[0] : r.shreg[7];
      end
      if (rise) begin
        n.sck_level = 1'b1;
        rx_byte = r.dir ? {si_sync, r.shreg[7:1]} : {r.shreg[6:0], si_sync};
        n.shreg = rx_byte;
        n.bitcnt = r.bitcnt + 3'h1;
        if (r.bitcnt == 3'h7) begin
          // received bytes land in the buffer
          if (r.mode != MODE_TX) begin
            n.mem[r.sptr] = rx_byte;
          end
          n.sptr = r.sptr + 5'h01;
          n.bytes_done = r.bytes_done + 6'h01;
          if (n.bytes_done == nbytes) begin
            n.shift_active = 1'b0;
            ev_done = 1'b1;
            if (r.mode != MODE_RX) begin
              n.tx_flag = 1'b1;
              n.wptr = '0;
            end
            if (r.mode != MODE_TX) begin
              rx_set = 1'b1;
              // unread previous block is an overrun
              rx_err_set = r.rx_flag;
            end
          end else begin
            n.shreg = n.mem[n.sptr];
          end
        end
      end
    end

    // ---- write channel: address and data taken in either order
    if (awvalid && !r.aw_got) begin
      n.aw_got = 1'b1;
      n.aw_idx = awaddr[11:2];
    end
    if (wvalid && !r.w_got) begin
      n.w_got = 1'b1;
      n.wbyte = wdata[7:0];
      n.wlane = wstrb[0];
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      wr_fire = 1'b1;
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      case (r.aw_idx)
        `IDX_CTRL_ONE: begin
          if (r.wlane) begin
            n.run = r.wbyte[`CTRL_RUN_BIT];
            n.abort = r.abort | r.wbyte[`CTRL_ABORT_BIT];
            n.mode = mode_type'(r.wbyte[`CTRL_MODE_LSB+:2]);
            n.dir = r.wbyte[`CTRL_DIR_BIT];
            n.sck_sel = r.wbyte[2:0];
            // stop ends the transfer, errors kept
            if (!r.wbyte[`CTRL_RUN_BIT]) begin
              n.xfer_active = 1'b0;
              n.shift_active = 1'b0;
              n.sck_level = 1'b1;
            end
          end
        end
        `IDX_CTRL_TWO: begin
          // upper bits are dropped; software keeps them zero
          if (r.wlane) begin
            n.count_field = r.wbyte[`COUNT_W-1:0];
          end
        end
        `IDX_DATA: begin
          // transmit bytes queue in the buffer
          if (r.wlane) begin
            n.mem[r.wptr] = r.wbyte;
            n.wptr = r.wptr + 5'h01;
            n.tx_flag = 1'b0;
            // loading while busy corrupts the stream
            tx_err_set = r.xfer_active;
          end
        end
        `IDX_STATUS: begin
          // writes are ignored: flags belong to hardware
        end
        `IDX_IRQ_STAT: begin
          if (r.wlane) begin
            n.irq_stat = r.irq_stat & ~r.wbyte[1:0];
          end
        end
        `IDX_IRQ_MASK: begin
          if (r.wlane) begin
            n.irq_mask = r.wbyte[1:0];
          end
        end
        default: n.bresp = `RESP_SLVERR;
      endcase
    end
    if (r.bvalid && bready) begin
      n.bvalid = 1'b0;
    end

    // ---- read channel
    if (arvalid && !r.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = `RESP_OKAY;
      n.rdata = '0;
      case (araddr[11:2])
        `IDX_CTRL_ONE: n.rdata[7:0] = {r.run, r.abort, r.mode, r.dir, r.sck_sel};
        `IDX_CTRL_TWO: n.rdata[7:0] = {3'b000, r.count_field};
        `IDX_STATUS: n.rdata[7:0] = status_byte;
        `IDX_DATA: begin
          n.rdata[7:0] = r.mem[r.rptr];
          n.rptr = r.rptr + 5'h01;
          n.rd_count = r.rd_count + 6'h01;
          // count reads release the receive flag
          if (n.rd_count == nbytes) begin
            n.rd_count = '0;
            n.rptr = '0;
            n.rx_flag = 1'b0;
          end
        end
        `IDX_IRQ_STAT: n.rdata[1:0] = r.irq_stat;
        `IDX_IRQ_MASK: n.rdata[1:0] = r.irq_mask;
        default: n.rresp = `RESP_SLVERR;
      endcase
    end
    if (r.rvalid && rready) begin
      n.rvalid = 1'b0;
    end

    // ---- receive, error and done events win over same-cycle bus clears; abort below still clears rx and error flags
    if (rx_set) begin
      n.rx_flag = 1'b1;
    end
    if (tx_err_set) begin
      n.tx_err = 1'b1;
    end
    if (rx_err_set) begin
      n.rx_err = 1'b1;
    end
    if (ev_done) begin
      n.irq_stat[`IRQ_DONE_BIT] = 1'b1;
    end
    if (tx_err_set || rx_err_set) begin
      n.irq_stat[`IRQ_ERR_BIT] = 1'b1;
    end

    // abort resets run and flags, then self-clears
    if (r.abort) begin
      n.abort = 1'b0;
      n.run = 1'b0;
      n.xfer_active = 1'b0;
      n.shift_active = 1'b0;
      n.tx_flag = 1'b1;
      n.rx_flag = 1'b0;
      n.tx_err = 1'b0;
      n.rx_err = 1'b0;
      n.mem = '0;
      n.wptr = '0;
      n.rptr = '0;
      n.sptr = '0;
      n.rd_count = '0;
      n.bytes_done = '0;
      n.bitcnt = '0;
      n.sck_level = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.tx_flag <= 1'b1;
      r.sck_level <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // outputs
  assign awready = !r.aw_got;
  assign wready = !r.w_got;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = !r.rvalid;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  // clock pin driven only from the internal source
  assign pins_out.sck_out = r.sck_level;
  assign pins_out.sck_oe = internal;
  assign pins_out.so_out = r.so;
  assign irq = |(r.irq_stat & r.irq_mask);

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_abort_flags: assert property (
    r.abort |=> (status_byte == `STATUS_RESET) && !r.run && !r.abort)
    else $error("abort did not reset flags and run");

  chk_abort_buffer: assert property (
    r.abort |=> (r.mem == '0) && (r.wptr == 5'h00) && (r.rptr == 5'h00))
    else $error("abort left buffer contents");

  chk_stop_ends: assert property (
    (wr_fire && r.wlane && r.aw_idx == `IDX_CTRL_ONE
     && !r.wbyte[`CTRL_RUN_BIT]) |=> !r.xfer_active && !r.shift_active)
    else $error("stop did not clear transfer active");

  chk_stop_errors: assert property (
    (r.xfer_active && !r.abort && n.run == 1'b0)
    |=> (r.tx_err || !$past(r.tx_err)) && (r.rx_err || !$past(r.rx_err)))
    else $error("error flag lost on stop");

  chk_rx_flag_set: assert property (
    (rx_set && !r.abort) |=> r.rx_flag)
    else $error("receive flag not set after count bytes");

  chk_shared_count: assert property (
    ($fell(r.shift_active) && r.xfer_active)
    |-> r.bytes_done == {1'b0, r.count_field} + 6'h01)
    else $error("shifter stopped at wrong byte count");

  chk_buffer_store: assert property (
    (wr_fire && r.wlane && r.aw_idx == `IDX_DATA && !r.abort)
    |=> r.mem[$past(r.wptr)] == $past(r.wbyte))
    else $error("buffer write not stored");

  chk_active_nest: assert property (
    r.shift_active |-> r.xfer_active)
    else $error("shift active outside a transfer");

  chk_status_low: assert property (
    (arvalid && !r.rvalid && araddr[11:2] == `IDX_STATUS)
    |=> r.rvalid && r.rdata[1:0] == 2'b00 && r.rdata[7] == $past(r.xfer_active))
    else $error("status read layout wrong");

  chk_irq_sticky: assert property (
    (r.irq_stat[`IRQ_DONE_BIT] && !wr_fire) |=> r.irq_stat[`IRQ_DONE_BIT])
    else $error("done status dropped without a clear");
endmodule
`default_nettype wire

/* sim/serial_peer.sv */
// external serial peripheral model facing the serial i/o pins
`default_nettype none
module serial_peer (
  input wire logic aclk,
  input wire logic sck,
  input wire logic so,
  input wire logic active,
  output logic si
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx_q [32];
  logic [7:0] rx_q [32];
  logic [7:0] sh;
  logic prev;
  int bitn;
  int byten;
  initial begin
    prev = 1'b1;
    si = 1'b0;
    sh = 8'h00;
    bitn = 0;
    byten = 0;
  end
  // outside a frame the data line is released: toggle so stale bits never match
  always @(posedge aclk) begin
    if (!active) begin
      si <= ~si;
      bitn = 0;
      byten = 0;
    end else if (prev && !sck) begin
      si <= tx_q[byten][7 - bitn];
    end else if (!prev && sck) begin
      sh = {sh[6:0], so};
      if (bitn == 7) begin
        rx_q[byten] = sh;
        byten = byten + 1;
        bitn = 0;
      end else begin
        bitn = bitn + 1;
      end
    end
    prev <= sck;
  end
endmodule
`default_nettype wire

/* sim/serial_io_status_and_buffer_test.sv */
// self-checking bench of the serial i/o status flags and data buffer
`default_nettype none
`include "serial_io_params.svh"
module serial_io_status_and_buffer_test;
  import serial_io_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_C1 = {`IDX_CTRL_ONE, 2'b00};
  localparam logic [11:0] A_C2 = {`IDX_CTRL_TWO, 2'b00};
  localparam logic [11:0] A_ST = {`IDX_STATUS, 2'b00};
  localparam logic [11:0] A_DB = {`IDX_DATA, 2'b00};
  localparam logic [11:0] A_IS = {`IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_IM = {`IDX_IRQ_MASK, 2'b00};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, active, gate, sck_ext, peer_si, peer_sck;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [7:0] tx [32];
  pins_out_type pins_out;
  pins_in_type pins_in;
  int seed, n, cyc, err_total, n_checks;

  serial_io i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pins_in(pins_in), .pins_out(pins_out), .irq(irq));
  assign pins_in.sck_in = sck_ext;
  assign pins_in.si_in = peer_si;
  assign peer_sck = pins_out.sck_oe ? pins_out.sck_out : sck_ext;
  serial_peer i_peer (.aclk(aclk), .sck(peer_sck), .so(pins_out.so_out), .active(active),
    .si(peer_si));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // link clock runs only inside frames, phase unrelated to aclk
  initial begin
    sck_ext = 1'b1;
    #13;
    forever begin
      #40;
      sck_ext = gate ? ~sck_ext : 1'b1;
    end
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end

  // ==========================================================
  // bus and compare tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e,
      input string nm);
    rd(a);
    chk(nm, {24'h000000, e}, d & {24'h000000, m});
  endtask
  task automatic xfer(input logic [7:0] c, input logic bad);
    int k;
    active <= 1'b1;
    wr(A_C1, c);
    if (bad) wr(A_DB, 8'h5a);
    k = 0;
    while (irq !== 1'b1 && k < 6000) begin
      @(posedge aclk);
      k++;
    end
    chk("irq on done", 1, irq);
    active <= 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    seed = 71567;
    {aresetn, awvalid, wvalid, arvalid, active, gate, cyc, err_total, n_checks} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    bready = 1'b1;
    rready = 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(A_ST, 8'hff, `STATUS_RESET, "status reset");
    rd(12'hffc);
    chk("unmapped resp", `RESP_SLVERR, r);
    wr(A_IM, 8'h01);
    chk("write resp", `RESP_OKAY, r);
    $display("test reset done");
    n = 1 + ($unsigned($random(seed)) % 4);
    for (int i = 0; i < n; i++) begin
      tx[i] = $random(seed);
      i_peer.tx_q[i] = $random(seed);
    end
    wr(A_C2, 8'(n - 1));
    for (int i = 0; i < n; i++) wr(A_DB, tx[i]);
    xfer(8'ha4, 1'b0);
    rchk(A_ST, 8'hff, 8'hb0, "status done");
    for (int i = 0; i < n; i++) chk("byte sent", tx[i], i_peer.rx_q[i]);
    wr(A_IM, 8'h00);
    chk("irq masked", 0, irq);
    wr(A_IM, 8'h01);
    wr(A_IS, 8'h03);
    chk("irq cleared", 0, irq);
    wr(A_C1, 8'h24);
    rchk(A_ST, 8'hff, 8'h30, "status stop");
    for (int i = 0; i < n; i++) rchk(A_DB, 8'hff, i_peer.tx_q[i], "byte got");
    rchk(A_ST, 8'hff, `STATUS_RESET, "status unloaded");
    $display("test exchange done");
    for (int i = 0; i < n; i++) wr(A_DB, tx[i]);
    xfer(8'ha4, 1'b1);
    wr(A_IS, 8'h03);
    wr(A_C1, 8'h24);
    rchk(A_ST, 8'hcc, 8'h08, "errors kept");
    $display("test error done");
    gate = 1'b1;
    xfer(8'h97, 1'b0);
    gate = 1'b0;
    wr(A_C1, 8'h57);
    repeat (2) @(posedge aclk);
    rchk(A_ST, 8'hff, `STATUS_RESET, "status abort");
    rchk(A_C1, 8'hc0, 8'h00, "run abort");
    rchk(A_DB, 8'hff, 8'h00, "buffer abort");
    chk("clock drive", 0, pins_out.sck_oe);
    $display("test abort done");
    close_out();
  end
endmodule
`default_nettype wire
